// [src/mlwcd_decoder.sv]
/*
 * Decoder for LIN writing frames of a stepper positioning slave. Frames come
 * in as a byte stream from the data-link layer, are checked, decoded and
 * turned into motion, parameter and fuse-programming outputs.
 * Assumes: byte stream and node address on clk_i; lin_rx_i is the raw pin;
 * the motion controller pulses motion_done_i when a move ends.
 */
// Our own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Broadcast reset clears present and goal positions
// - Continuous-run command enters continuous motion state
// - Continuous run ignores rotation-sense bit
// - Bus silence in run starts fallback motion
// - Run command from two-byte frame, bit7 set
// - Byte two: low broadcast select, node address
// - Extended frames: id 0x3C, marker, command, address
// - Dual move: speed nibbles, two positions MSB first
// - First leg both speeds, second low only
// - Second position relative to first leg end
// - Dual move completion sets reference-done
// - Dual move cannot be aborted by positioning
// - Stall command loads stall and motor parameters
// - Stall last byte split into five fields
// - Motor command loads parameters and fallback position
// - Motor last byte needs ones at 7,5,1
// - Motor parameters apply at once, mid-motion
// - Fuse command writes byte at 3-bit index
// - Broadcast fuse or parameter write hits every node
// - Absolute move dropped when priority logic rejects
// - Signed 16-bit absolute target per motor
module mlwcd_decoder #(
	parameter int LOST_CYCLES = mlwcd_pkg::LOST_CYCLES
) (
	// Clock and reset
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	// Wishbone slave
	input  wire logic               wb_cyc_i,
	input  wire logic               wb_stb_i,
	input  wire logic               wb_we_i,
	input  wire logic [7:0]         wb_adr_i,
	input  wire logic [31:0]        wb_dat_i,
	input  wire logic [3:0]         wb_sel_i,
	output logic [31:0]             wb_dat_o,
	output logic                    wb_ack_o,
	// Received frame byte stream
	input  wire logic               frame_start_i,
	input  wire logic               byte_valid_i,
	input  wire logic [7:0]         byte_i,
	input  wire logic               frame_end_i,
	input  wire logic               lin_rx_i,
	// Node and motion controller state
	input  wire logic [6:0]         node_addr_i,
	input  wire logic               motion_done_i,
	input  wire logic signed [15:0] present_position_i,
	// Motion commands
	output logic                    pos_clear_o,
	output logic                    target_load_o,
	output logic signed [15:0]      target_o,
	output logic [3:0]              move_vmax_o,
	output logic [3:0]              move_vmin_o,
	output logic                    run_mode_o,
	output logic                    shaft_eff_o,
	output logic                    fallback_start_o,
	output logic                    reference_done_o,
	// Parameter RAM
	output logic                    param_write_o,
	output logic [3:0]              run_current_o,
	output logic [3:0]              hold_current_o,
	output logic [3:0]              vmax_o,
	output logic [3:0]              vmin_o,
	output logic [3:0]              acc_o,
	output logic [2:0]              stall_samples_o,
	output logic [3:0]              stall_abs_thr_o,
	output logic [3:0]              stall_delta_thr_o,
	output logic [2:0]              fullstep_stall_en_o,
	output logic                    ramp_profile_o,
	output logic [1:0]              step_res_o,
	output logic                    full_duty_stall_en_o,
	output logic                    pwm_jitter_en_o,
	output logic                    chop_freq_o,
	output logic [10:0]             safe_pos_o,
	// Fuse memory
	output logic                    fuse_write_o,
	output logic [2:0]              fuse_index_o,
	output logic [7:0]              fuse_data_o
);

	// Addressed when broadcast select is low or address matches
	function automatic logic hit_f(input logic broad, input logic [6:0] adr,
	                               input logic [6:0] own);
		hit_f = !broad || (adr == own);
	endfunction

	// Classic checksum: carry-add over data and checksum bytes gives all ones
	function automatic logic csum_ok_f(input logic [7:0] b [0:9], input logic [3:0] n);
		logic [8:0] s;
		s = '0;
		for (int i = 1; i < mlwcd_pkg::MAX_BYTES; i++) begin
			if (4'(i) < n) begin
				s = {1'b0, s[7:0]} + {1'b0, b[i]} + {8'h00, s[8]};
			end
		end
		s = {1'b0, s[7:0]} + {8'h00, s[8]};
		csum_ok_f = (s[7:0] == mlwcd_pkg::CSUM_GOOD);
	endfunction

	logic [7:0]            buf_r [0:9];
	logic [3:0]            cnt_r;
	logic                  ovf_r;
	logic                  rx_s1_r, rx_s2_r, rx_s3_r;
	logic [31:0]           lost_cnt_r;
	logic [5:0]            gp2_id_r;
	logic                  lost_r, ferr_r;
	mlwcd_pkg::mlwcd_dual_t dual_r;
	logic                  shaft_cfg_r;
	logic signed [15:0]    second_offset_r;

	// Frame checks
	wire [7:0]  idb       = buf_r[mlwcd_pkg::B_ID];
	wire [5:0]  id6       = idb[5:0];
	wire        p0        = idb[0] ^ idb[1] ^ idb[2] ^ idb[4];
	wire        p1        = !(idb[1] ^ idb[3] ^ idb[4] ^ idb[5]);
	wire        parity_ok = (idb[6] == p0) && (idb[7] == p1);
	wire        csum_ok   = csum_ok_f(buf_r, cnt_r);
	wire        frame_ok  = frame_end_i && !ovf_r && (cnt_r >= mlwcd_pkg::MIN_BYTES)
	                        && parity_ok && csum_ok;
	wire        frame_bad = frame_end_i && !frame_ok;

	// Two-byte general-purpose frame decode
	// command only from data byte one
	wire        gp_frm   = frame_ok && (id6 == gp2_id_r) && (cnt_r == mlwcd_pkg::GP_BYTES)
	                       && buf_r[mlwcd_pkg::B_D1][mlwcd_pkg::CMD_BIT];
	wire [6:0]  gp_cmd   = buf_r[mlwcd_pkg::B_D1][6:0];
	wire        gp_hit   = hit_f(buf_r[mlwcd_pkg::B_D2][7], buf_r[mlwcd_pkg::B_D2][6:0],
	                             node_addr_i);

	// Extended 0x3C frame decode
	// fixed id, marker, command, address
	wire        ext_frm  = frame_ok && (id6 == mlwcd_pkg::EXT_ID)
	                       && (cnt_r == mlwcd_pkg::EXT_BYTES)
	                       && (buf_r[mlwcd_pkg::B_D1] == mlwcd_pkg::EXT_MARKER)
	                       && buf_r[mlwcd_pkg::B_D2][mlwcd_pkg::CMD_BIT];
	wire [6:0]  ext_cmd  = buf_r[mlwcd_pkg::B_D2][6:0];
	wire        ext_hit  = hit_f(buf_r[mlwcd_pkg::B_D3][7], buf_r[mlwcd_pkg::B_D3][6:0],
	                             node_addr_i);
	wire [7:0]  d4 = buf_r[mlwcd_pkg::B_D4];
	wire [7:0]  d5 = buf_r[mlwcd_pkg::B_D5];
	wire [7:0]  d6 = buf_r[mlwcd_pkg::B_D6];
	wire [7:0]  d7 = buf_r[mlwcd_pkg::B_D7];
	wire [7:0]  d8 = buf_r[mlwcd_pkg::B_D8];
	wire        dual_busy = (dual_r != mlwcd_pkg::DUAL_IDLE);

	// Accepted commands
	// reset position on broadcast or match
	wire acc_reset = gp_frm && (gp_cmd == mlwcd_pkg::CMD_RESET_POS) && gp_hit && !dual_busy;
	wire acc_run   = gp_frm && (gp_cmd == mlwcd_pkg::CMD_RUN) && gp_hit && !dual_busy;
	wire acc_dual  = ext_frm && (ext_cmd == mlwcd_pkg::CMD_DUAL) && ext_hit && !dual_busy;
	wire acc_stall = ext_frm && (ext_cmd == mlwcd_pkg::CMD_STALL) && ext_hit;
	wire acc_motor = ext_frm && (ext_cmd == mlwcd_pkg::CMD_MOTOR) && ext_hit
	                 && ((d8 & mlwcd_pkg::MOTOR_ONES) == mlwcd_pkg::MOTOR_ONES);
	// index ones and fill bytes checked
	wire acc_fuse  = ext_frm && (ext_cmd == mlwcd_pkg::CMD_FUSE) && ext_hit
	                 && (d4[7:3] == mlwcd_pkg::FUSE_ONES) && (d6 == mlwcd_pkg::FUSE_FILL)
	                 && (d7 == mlwcd_pkg::FUSE_FILL) && (d8 == mlwcd_pkg::FUSE_FILL);
	wire abs_hit1  = (buf_r[mlwcd_pkg::B_D3][6:0] == node_addr_i);
	wire abs_hit2  = (d6[6:0] == node_addr_i);
	wire abs_frm   = ext_frm && (ext_cmd == mlwcd_pkg::CMD_ABS) && (abs_hit1 || abs_hit2);
	// no positioning while dual move runs
	wire acc_abs   = abs_frm && !dual_busy;
	wire signed [15:0] abs_target = abs_hit1 ? {d4, d5} : {d7, d8};

	// Dual move sequence next values
	// second leg relative to first end
	wire signed [15:0] sec_target = present_position_i + second_offset_r;
	wire first_done  = (dual_r == mlwcd_pkg::DUAL_FIRST) && motion_done_i;
	wire second_done = (dual_r == mlwcd_pkg::DUAL_SECOND) && motion_done_i;

	// Pin synchroniser and activity detect
	wire activity    = (rx_s2_r ^ rx_s3_r) || frame_start_i;
	// silence during run means lost link
	wire lost_hit    = run_mode_o && !activity && (lost_cnt_r == 32'(LOST_CYCLES - 1));

	// Wishbone decode
	wire        wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// Writes commit at the edge that sees ack, when the master ends the cycle
	wire        wb_fin   = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
	wire        wr_ctrl  = wb_fin && (wb_adr_i == mlwcd_pkg::REG_CTRL);
	wire        wr_stat  = wb_fin
	                       && (wb_adr_i == mlwcd_pkg::REG_STATUS);
	wire [4:0]  status   = {ferr_r, lost_r, reference_done_o, dual_busy, run_mode_o};
	wire [31:0] rd_data  = (wb_adr_i == mlwcd_pkg::REG_CTRL)   ? {26'h0, gp2_id_r} :
	                       (wb_adr_i == mlwcd_pkg::REG_STATUS) ? {27'h0, status}   : 32'h0;

	// Frame byte capture; bytes past the buffer mark the frame as overrun
	always_ff @(posedge clk_i) begin
		if (rst_i || frame_start_i) begin
			cnt_r <= 4'h0;
			ovf_r <= 1'b0;
		end else if (byte_valid_i) begin
			if (cnt_r == mlwcd_pkg::EXT_BYTES) begin
				ovf_r <= 1'b1;
			end else begin
				buf_r[cnt_r] <= byte_i;
				cnt_r        <= cnt_r + 4'h1;
			end
		end
	end

	// Two-flop synchroniser plus edge history for the raw pin
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_s1_r <= 1'b1;
			rx_s2_r <= 1'b1;
			rx_s3_r <= 1'b1;
		end else begin
			rx_s1_r <= lin_rx_i;
			rx_s2_r <= rx_s1_r;
			rx_s3_r <= rx_s2_r;
		end
	end

	// Bus silence timer, running only in continuous run
	// timer restarts on any activity
	always_ff @(posedge clk_i) begin
		if (rst_i || !run_mode_o || activity || lost_hit) begin
			lost_cnt_r <= 32'h0;
		end else begin
			lost_cnt_r <= lost_cnt_r + 32'h1;
		end
	end

	// Continuous run mode, fallback start and shaft gating
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			run_mode_o       <= 1'b0;
			fallback_start_o <= 1'b0;
			shaft_eff_o      <= 1'b0;
		end else begin
			fallback_start_o <= lost_hit;
			// run until lost link or new move
			if (lost_hit || acc_abs || acc_dual) begin
				run_mode_o <= 1'b0;
			end else if (acc_run) begin
				run_mode_o <= 1'b1;
			end
			shaft_eff_o <= (acc_run || (run_mode_o && !lost_hit && !acc_abs && !acc_dual))
			               ? 1'b0 : shaft_cfg_r;
		end
	end

	// Dual-speed sequence and target loading
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dual_r        <= mlwcd_pkg::DUAL_IDLE;
			target_o      <= '0;
			target_load_o <= 1'b0;
			move_vmax_o   <= 4'h0;
			move_vmin_o   <= 4'h0;
			second_offset_r        <= '0;
		end else begin
			target_load_o <= 1'b0;
			unique case (dual_r)
				mlwcd_pkg::DUAL_IDLE: begin
					if (acc_dual) begin
						dual_r        <= mlwcd_pkg::DUAL_FIRST;
						target_o      <= {d5, d6};
						second_offset_r        <= {d7, d8};
						move_vmax_o   <= d4[7:4];
						move_vmin_o   <= d4[3:0];
						target_load_o <= 1'b1;
					end else if (acc_abs) begin
						target_o      <= abs_target;
						move_vmax_o   <= vmax_o;
						move_vmin_o   <= vmin_o;
						target_load_o <= 1'b1;
					end
				end
				mlwcd_pkg::DUAL_FIRST: begin
					// second leg at low speed only
					if (first_done) begin
						dual_r        <= mlwcd_pkg::DUAL_SECOND;
						target_o      <= sec_target;
						move_vmax_o   <= move_vmin_o;
						target_load_o <= 1'b1;
					end
				end
				mlwcd_pkg::DUAL_SECOND: begin
					if (second_done) begin
						dual_r <= mlwcd_pkg::DUAL_IDLE;
					end
				end
				default: begin
					dual_r <= mlwcd_pkg::DUAL_IDLE;
				end
			endcase
		end
	end

	// Position clear, reference flag and fuse write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pos_clear_o      <= 1'b0;
			reference_done_o <= 1'b0;
			fuse_write_o     <= 1'b0;
			fuse_index_o     <= 3'h0;
			fuse_data_o      <= 8'h00;
		end else begin
			pos_clear_o  <= acc_reset;
			fuse_write_o <= acc_fuse;
			// set on completion or position reset, set beats clear
			if (second_done || acc_reset) begin
				reference_done_o <= 1'b1;
			end else if (wr_stat && wb_dat_i[mlwcd_pkg::ST_REFDONE]) begin
				reference_done_o <= 1'b0;
			end
			// index from low bits, data byte five
			if (acc_fuse) begin
				fuse_index_o <= d4[2:0];
				fuse_data_o  <= d5;
			end
		end
	end

	// Parameter RAM image, updated at once even mid-motion
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			param_write_o        <= 1'b0;
			{run_current_o, hold_current_o, vmax_o, vmin_o, acc_o} <= '0;
			{stall_samples_o, stall_abs_thr_o, stall_delta_thr_o}  <= '0;
			{fullstep_stall_en_o, ramp_profile_o, step_res_o}      <= '0;
			{full_duty_stall_en_o, pwm_jitter_en_o, chop_freq_o}   <= '0;
			safe_pos_o           <= 11'h000;
			shaft_cfg_r          <= 1'b0;
		end else begin
			// new values reach the running move
			param_write_o <= acc_stall || acc_motor;
			if (acc_stall || acc_motor) begin
				run_current_o  <= d4[7:4];
				hold_current_o <= d4[3:0];
				vmax_o         <= d5[7:4];
				vmin_o         <= d5[3:0];
				shaft_cfg_r    <= d6[4];
				acc_o          <= d6[3:0];
				ramp_profile_o <= d8[4];
				pwm_jitter_en_o <= d8[0];
			end
			// last byte split high to low
			if (acc_stall) begin
				stall_samples_o      <= d6[7:5];
				stall_abs_thr_o      <= d7[7:4];
				stall_delta_thr_o    <= d7[3:0];
				fullstep_stall_en_o  <= d8[7:5];
				step_res_o           <= d8[3:2];
				full_duty_stall_en_o <= d8[1];
			end
			if (acc_motor) begin
				safe_pos_o  <= {d6[7:5], d7};
				chop_freq_o <= d8[6];
				step_res_o  <= d8[3:2];
			end
		end
	end

	// Sticky status flags and control register; events win over clears
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gp2_id_r <= mlwcd_pkg::GP2_ID_RST;
			lost_r   <= 1'b0;
			ferr_r   <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				gp2_id_r <= wb_dat_i[5:0];
			end
			if (lost_hit) begin
				lost_r <= 1'b1;
			end else if (wr_stat && wb_dat_i[mlwcd_pkg::ST_LOST]) begin
				lost_r <= 1'b0;
			end
			if (frame_bad) begin
				ferr_r <= 1'b1;
			end else if (wr_stat && wb_dat_i[mlwcd_pkg::ST_FRAMEERR]) begin
				ferr_r <= 1'b0;
			end
		end
	end

	// Wishbone answer: one wait state, ack for one cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= wb_req ? rd_data : 32'h0;
		end
	end

	// Checks on the decoder's own outputs
	property p_reset_clears;
		@(posedge clk_i) disable iff (rst_i) acc_reset |=> pos_clear_o && reference_done_o;
	endproperty
	a_reset_clears: assert property (p_reset_clears) else $error("reset position lost");
	property p_run_enter;
		@(posedge clk_i) disable iff (rst_i) acc_run && !lost_hit |=> run_mode_o;
	endproperty
	a_run_enter: assert property (p_run_enter) else $error("run mode not entered");
	property p_run_shaft;
		@(posedge clk_i) disable iff (rst_i) run_mode_o |-> !shaft_eff_o;
	endproperty
	a_run_shaft: assert property (p_run_shaft) else $error("shaft used in run mode");
	property p_lost;
		@(posedge clk_i) disable iff (rst_i) lost_hit |=> fallback_start_o && !run_mode_o
			##1 !fallback_start_o;
	endproperty
	a_lost: assert property (p_lost) else $error("fallback not started once");
	property p_dual_load;
		@(posedge clk_i) disable iff (rst_i) acc_dual |=> target_load_o
			&& target_o == $past({d5, d6}) && move_vmax_o == $past(d4[7:4]);
	endproperty
	a_dual_load: assert property (p_dual_load) else $error("dual move fields wrong");
	property p_second_speed;
		@(posedge clk_i) disable iff (rst_i) dual_r == mlwcd_pkg::DUAL_SECOND
			|-> move_vmax_o == move_vmin_o;
	endproperty
	a_second_speed: assert property (p_second_speed) else $error("second leg speed wrong");
	property p_refdone;
		@(posedge clk_i) disable iff (rst_i) second_done |=> reference_done_o && !dual_busy;
	endproperty
	a_refdone: assert property (p_refdone) else $error("reference done not set");
	property p_no_abort;
		@(posedge clk_i) disable iff (rst_i) abs_frm && dual_busy && !motion_done_i
			|=> !target_load_o;
	endproperty
	a_no_abort: assert property (p_no_abort) else $error("dual move aborted");
	property p_motor_ones;
		@(posedge clk_i) disable iff (rst_i) ext_frm && ext_cmd == mlwcd_pkg::CMD_MOTOR
			&& (d8 & mlwcd_pkg::MOTOR_ONES) != mlwcd_pkg::MOTOR_ONES |=> !param_write_o;
	endproperty
	a_motor_ones: assert property (p_motor_ones) else $error("bad motor frame taken");
	property p_bad_frame;
		@(posedge clk_i) disable iff (rst_i) frame_bad && !motion_done_i
			|=> !(target_load_o || param_write_o || fuse_write_o || pos_clear_o);
	endproperty
	a_bad_frame: assert property (p_bad_frame) else $error("bad frame executed");
	c_run: cover property (@(posedge clk_i) disable iff (rst_i) acc_run);
	c_dual: cover property (@(posedge clk_i) disable iff (rst_i) second_done);
	c_fuse: cover property (@(posedge clk_i) disable iff (rst_i) acc_fuse);
	c_lost: cover property (@(posedge clk_i) disable iff (rst_i) lost_hit);

endmodule

`default_nettype wire

// [src/mlwcd_pkg.sv]
/*
 * Shared constants for the LIN writing-frame command decoder: timing, frame
 * layout, command codes, register map and the dual-move state type.
 * Assumes a single 100 MHz device clock.
 */
package mlwcd_pkg;
	// Clock and lost-communication timing
	localparam int CLK_FREQ_MHZ = 100;
	localparam int LOST_TIME_US = 1000;
	localparam int LOST_CYCLES  = LOST_TIME_US * CLK_FREQ_MHZ;

	// Frame buffer geometry: identifier, up to eight data bytes, checksum
	localparam int         MAX_BYTES    = 10;
	localparam logic [3:0] MIN_BYTES    = 4'h3;
	localparam logic [3:0] GP_BYTES     = 4'h4;
	localparam logic [3:0] EXT_BYTES    = 4'ha;
	localparam int         B_ID         = 0;
	localparam int         B_D1         = 1;
	localparam int         B_D2         = 2;
	localparam int         B_D3         = 3;
	localparam int         B_D4         = 4;
	localparam int         B_D5         = 5;
	localparam int         B_D6         = 6;
	localparam int         B_D7         = 7;
	localparam int         B_D8         = 8;
	localparam int         CMD_BIT      = 7;

	// Fixed identifiers and markers
	localparam logic [5:0] EXT_ID       = 6'h3c;
	localparam logic [7:0] EXT_MARKER   = 8'h80;
	localparam logic [5:0] GP2_ID_RST   = 6'h00;
	localparam logic [7:0] CSUM_GOOD    = 8'hff;

	// Command codes
	localparam logic [6:0] CMD_RESET_POS = 7'h06;
	localparam logic [6:0] CMD_RUN       = 7'h17;
	localparam logic [6:0] CMD_DUAL      = 7'h08;
	localparam logic [6:0] CMD_STALL     = 7'h16;
	localparam logic [6:0] CMD_MOTOR     = 7'h09;
	localparam logic [6:0] CMD_FUSE      = 7'h10;
	localparam logic [6:0] CMD_ABS       = 7'h0b;

	// Fixed bit patterns inside command frames
	localparam logic [7:0] MOTOR_ONES   = 8'ha2;
	localparam logic [4:0] FUSE_ONES    = 5'h1f;
	localparam logic [7:0] FUSE_FILL    = 8'hff;

	// Register map (byte addresses) and fields
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_STATUS   = 8'h04;
	localparam int         ST_RUN       = 0;
	localparam int         ST_DUAL      = 1;
	localparam int         ST_REFDONE   = 2;
	localparam int         ST_LOST      = 3;
	localparam int         ST_FRAMEERR  = 4;

	// Dual-speed move sequence
	typedef enum logic [1:0] {
		DUAL_IDLE   = 2'b00,
		DUAL_FIRST  = 2'b01,
		DUAL_SECOND = 2'b11
	} mlwcd_dual_t;
endpackage

// [sim/mlwcd_lin_master.sv]
/* Bus master stand-in: sends frames to the decoder as a byte stream with
   protected identifier and classic checksum. Assumes the decoder's clock. */
`timescale 1ns/1ps
`default_nettype none
module mlwcd_lin_master (
	// Clock
	input  wire logic  clk_i,
	// Byte stream and bus pin
	output logic       frame_start_o,
	output logic       byte_valid_o,
	output logic [7:0] byte_o,
	output logic       frame_end_o,
	output logic       lin_rx_o
);
	int         gap = 0;
	logic [8:0] sum;
	// Idle stream, recessive bus
	initial begin
		frame_start_o = 1'b0;
		byte_valid_o = 1'b0;
		byte_o = 8'h00;
		frame_end_o = 1'b0;
		lin_rx_o = 1'b1;
	end
	// One byte; pin toggles, released data shows its inverse
	task put(input logic [7:0] b, input logic last);
		byte_o <= b;
		byte_valid_o <= 1'b1;
		lin_rx_o <= ~lin_rx_o;
		@(posedge clk_i);
		// Valid stays up between back-to-back bytes
		if (last || gap > 0) begin
			byte_valid_o <= 1'b0;
			byte_o <= ~b;
		end
		repeat (gap) @(posedge clk_i);
	endtask
	task send(input logic [5:0] id, input int n, input logic [63:0] d, input logic bad);
		sum = 9'h000;
		frame_start_o <= 1'b1;
		@(posedge clk_i);
		frame_start_o <= 1'b0;
		put({~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id}, 1'b0);
		for (int i = 0; i < n; i++) begin
			sum = sum[7:0] + sum[8] + d[63 - 8 * i -: 8];
			put(d[63 - 8 * i -: 8], 1'b0);
		end
		sum = sum[7:0] + sum[8];
		put(~sum[7:0] ^ {7'h00, bad}, 1'b1);
		frame_end_o <= 1'b1;
		@(posedge clk_i);
		frame_end_o <= 1'b0;
		lin_rx_o <= 1'b1;
	endtask
endmodule
`default_nettype wire

// [sim/mlwcd_decoder_tb_top.sv]
/* Bench for the writing-frame decoder: a table of extended frames, then
   hand tests. Assumes the master model drives the byte stream. */
`timescale 1ns/1ps
`default_nettype none
module mlwcd_decoder_tb_top;
	localparam int         LOST = 20;
	localparam logic [5:0] GP   = 6'h11;
	localparam logic [5:0] EXT  = mlwcd_pkg::EXT_ID;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, frame_start_i, byte_valid_i;
	logic frame_end_i, lin_rx_i, motion_done_i, pos_clear_o, target_load_o, run_mode_o;
	logic shaft_eff_o, fallback_start_o, reference_done_o, param_write_o, ramp_profile_o;
	logic full_duty_stall_en_o, pwm_jitter_en_o, chop_freq_o, fuse_write_o;
	logic [7:0]  wb_adr_i, byte_i, fuse_data_o;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	logic [3:0]  wb_sel_i, move_vmax_o, move_vmin_o, run_current_o, hold_current_o, vmax_o;
	logic [3:0]  vmin_o, acc_o, stall_abs_thr_o, stall_delta_thr_o;
	logic [2:0]  stall_samples_o, fullstep_stall_en_o, fuse_index_o;
	logic [1:0]  step_res_o;
	logic [10:0] safe_pos_o;
	logic [6:0]  node_addr_i;
	logic signed [15:0] present_position_i, target_o;
	logic [63:0] row;
	int failures = 0, n_tests = 0, cyc = 0, cnt[5] = '{default: 0}, base[5];
	wire logic [4:0] pv = {fallback_start_o, pos_clear_o, target_load_o, fuse_write_o,
		param_write_o};
	// Command, address, bytes four to eight, kind: 0 stall 1 motor 2 fuse 3 ignored
	logic [63:0] rows[7] = '{64'h96aa5ac3b7e1b500, 64'h89051273d69ce201,
		64'h90aafd3cffffff02, 64'h96ab111111111103, 64'h89aa123456780003,
		64'h907ff8a5ffffff02, 64'h89aafedc5567bf01};
	mlwcd_decoder #(.LOST_CYCLES(LOST)) u_mlwcd_decoder (.*);
	mlwcd_lin_master u_mlwcd_lin_master (.clk_i(clk_i), .frame_start_o(frame_start_i),
		.byte_valid_o(byte_valid_i), .byte_o(byte_i), .frame_end_o(frame_end_i),
		.lin_rx_o(lin_rx_i));
	always #5 clk_i = ~clk_i;
	// Pulse counters and run limit
	always @(posedge clk_i) begin
		for (int k = 0; k < 5; k++) cnt[k] <= cnt[k] + int'(pv[k]);
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			end_sim();
		end
	end
	function automatic logic [3:0] hit();
		for (int k = 0; k < 4; k++) hit[k] = (cnt[k] != base[k]);
	endfunction
	task chk(input logic [63:0] g, input logic [63:0] e);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("Error at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	// Classic single cycle, held until ack
	task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, d, 4'hf};
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1) @(posedge clk_i);
		q = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
		@(posedge clk_i);
	endtask
	task fr(input logic [5:0] id, input int n, input logic [63:0] d, input logic bad);
		base = cnt;
		u_mlwcd_lin_master.send(id, n, d, bad);
		repeat (3) @(posedge clk_i);
	endtask
	task done;
		base = cnt;
		motion_done_i <= 1'b1;
		@(posedge clk_i);
		motion_done_i <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask
	task end_sim;
		$display("Comparisons %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		{clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, motion_done_i} = 6'h10;
		{wb_adr_i, wb_dat_i, wb_sel_i, present_position_i} = '0;
		node_addr_i = 7'h2a;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk({run_mode_o, reference_done_o, param_write_o, target_o}, 19'h0);
		wb(1'b1, mlwcd_pkg::REG_CTRL, {26'h0, GP});
		// Table of extended frames
		for (int r = 0; r < 7; r++) begin
			row = rows[r];
			fr(EXT, 8, {mlwcd_pkg::EXT_MARKER, row[63:8]}, 1'b0);
			chk(hit(), {row[1:0] == 2'd2, row[1:0] < 2'd2});
			if (row[1:0] == 2'd0)
				chk({run_current_o, hold_current_o, vmax_o, vmin_o, stall_samples_o, acc_o,
					stall_abs_thr_o, stall_delta_thr_o, fullstep_stall_en_o, ramp_profile_o,
					step_res_o, full_duty_stall_en_o, pwm_jitter_en_o},
					{row[47:29], row[27:8]});
			if (row[1:0] == 2'd1)
				chk({run_current_o, hold_current_o, vmax_o, vmin_o, safe_pos_o[10:8], acc_o,
					safe_pos_o[7:0], chop_freq_o, ramp_profile_o, step_res_o, pwm_jitter_en_o},
					{row[47:29], row[27:16], row[14], row[12:10], row[8]});
			if (row[1:0] == 2'd2)
				chk({fuse_index_o, fuse_data_o}, row[42:32]);
		end
		// Corrupted checksum, status flag, unmapped read
		fr(EXT, 8, {8'h80, rows[6][63:8]}, 1'b1);
		chk(hit(), 4'h0);
		wb(1'b0, mlwcd_pkg::REG_STATUS, 32'h0);
		chk(q[4], 1'b1);
		wb(1'b1, mlwcd_pkg::REG_STATUS, 32'h10);
		wb(1'b0, mlwcd_pkg::REG_STATUS, 32'h0);
		chk(q[4], 1'b0);
		wb(1'b0, 8'h40, 32'h0);
		chk(q, 32'h0);
		// Two-speed move on a slower stream
		u_mlwcd_lin_master.gap = 2;
		fr(EXT, 8, 64'h8088aa730123fff0, 1'b0);
		chk({hit(), target_o, move_vmax_o, move_vmin_o}, 28'h4012373);
		// Mid-motion parameter frame; only the speed indices are checked
		fr(EXT, 8, 64'h8089aafe735567bf, 1'b0);
		chk({hit(), vmax_o, vmin_o}, 12'h173);
		fr(EXT, 8, 64'h808baa4000800000, 1'b0);
		chk(hit(), 4'h0);
		present_position_i <= 16'sh0123;
		done;
		chk({hit(), target_o, move_vmax_o, move_vmin_o, reference_done_o}, 29'h8022666);
		done;
		chk({hit(), reference_done_o}, 5'h01);
		fr(EXT, 8, 64'h808baa8001800000, 1'b0);
		chk({hit(), target_o, shaft_eff_o}, 21'h90003);
		// Second motor slot of the absolute move carries our address
		fr(EXT, 8, 64'h808b911234aa7ffe, 1'b0);
		chk({hit(), target_o}, 20'h47ffe);
		// Continuous run, then bus silence
		fr(GP, 2, {16'h1705, 48'h0}, 1'b0);
		chk(run_mode_o, 1'b0);
		fr(GP, 2, {16'h9705, 48'h0}, 1'b0);
		chk({run_mode_o, shaft_eff_o}, 2'b10);
		base = cnt;
		repeat (LOST + 20) @(posedge clk_i);
		chk({cnt[4] != base[4], run_mode_o}, 2'b10);
		fr(GP, 2, {16'h8605, 48'h0}, 1'b0);
		chk({hit(), reference_done_o}, 5'h11);
		end_sim();
	end
endmodule
`default_nettype wire
